// >>> inc/spcp_pkg.sv
// Package: constants, types and register map of the slave parallel configuration port
package spcp_pkg;

    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_LENGTH = 8'h04;
    localparam logic [7:0] ADDR_CHECK  = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_COUNT  = 8'h10;
    localparam logic [7:0] ADDR_LAST   = 8'h14;

    // Control fields
    localparam int CTRL_PROG_BIT = 0;
    localparam int CTRL_LOCK_BIT = 1;

    // Status fields
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_DONE_BIT  = 8;
    localparam int STAT_ERROR_BIT = 9;
    localparam int STAT_BUSY_BIT  = 10;
    localparam int STAT_MODE_LSB  = 12;

    // Reset values
    localparam logic [31:0] LENGTH_RST = 32'h0000_0010;
    localparam logic [7:0]  CHECK_RST  = 8'h00;

    // Mode pin codes
    localparam logic [2:0] MODE_PARALLEL = 3'h6;
    localparam logic [2:0] MODE_JTAG     = 3'h5;
    localparam logic [2:0] MODE_FLASH    = 3'h2;

    // Timing
    localparam int CLK_PERIOD_NS   = 25;
    localparam int CLEAR_NS        = 1000;
    localparam int CLEAR_CYCLES    = (CLEAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] CLEAR_CNT_MAX = 8'(CLEAR_CYCLES - 1);
    localparam logic [7:0] STARTUP_CYCLES = 8'h08;

    // Loader states
    typedef enum logic [5:0] {
        ST_CLEAR = 6'h01,
        ST_INIT  = 6'h02,
        ST_LOAD  = 6'h04,
        ST_START = 6'h08,
        ST_DONE  = 6'h10,
        ST_ERROR = 6'h20
    } spcp_state_e;

    // Parallel port pins from the host
    typedef struct packed {
        logic       select_n;
        logic       write_direction_n;
        logic [7:0] data;
    } spcp_par_s;

    // Boundary-scan pins
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } spcp_jtag_s;

endpackage

// >>> rtl/spcp_sync.sv
// Two-flop synchroniser for a vector of independent levels
`timescale 1ns/1ps
module spcp_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Levels
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_reg; // First stage, read only by q

    // Both stages per bit
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    meta_reg[i] <= 1'b0;
                    q[i]        <= 1'b0;
                end else begin
                    meta_reg[i] <= d[i];
                    q[i]        <= meta_reg[i];
                end
            end
        end
    endgenerate

endmodule // spcp_sync

// >>> rtl/spcp_top.sv
// Slave parallel configuration loader with AHB-Lite register access
`timescale 1ns/1ps
module spcp_top #(
    parameter int STEPPING = 1
) (
    // AHB-Lite system side
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic [31:0]            hrdata,
    // Configuration pins
    input  wire logic              config_clock,
    input  wire logic              program_request_n,
    input  wire logic [2:0]        mode_pins,
    input  wire spcp_pkg::spcp_par_s par_in,
    output logic                   busy,
    output logic                   done,
    // Open-drain init status line
    input  wire logic              init_in,
    output logic                   init_out,
    output logic                   init_oe,
    // Boundary-scan port
    input  wire spcp_pkg::spcp_jtag_s jtag_in,
    output logic                   tdo,
    // Start-up and flash hints
    input  wire logic              clock_manager_locked,
    input  wire logic              flash_image_valid
);

    // ---------------- Cross-domain signals ----------------
    logic        load_open_reg;  // Parallel loading allowed, hclk side
    logic        start_req_reg;  // Start-up requested, hclk side
    logic        ack_tgl_reg;    // Byte acknowledge toggle, hclk side
    logic        req_tgl_reg;    // Byte request toggle, link side
    logic        sdone_reg;      // Start-up finished, link side
    logic [7:0]  ldata_reg;      // Captured byte, link side
    logic [31:0] ctrl_reg;       // Control register

    logic [4:0]  lsync_q;        // Levels seen by link domain
    logic        open_l;
    logic        start_l;
    logic        ack_l;
    logic        lock_l;
    logic        wait_l;

    logic [10:0] hsync_q;        // Levels seen by hclk domain
    logic        prog_h;
    logic        init_h;
    logic [2:0]  mode_h;
    logic        tck_h;
    logic        tms_h;
    logic        tdi_h;
    logic        req_h;
    logic        sdone_h;
    logic        flash_h;

    // Into the link domain
    spcp_sync #(.W(5)) u_link_sync (
        .clk   (config_clock),
        .rst_n (hresetn),
        .d     ({load_open_reg, start_req_reg, ack_tgl_reg,
                 clock_manager_locked, ctrl_reg[spcp_pkg::CTRL_LOCK_BIT]}),
        .q     (lsync_q)
    );
    assign {open_l, start_l, ack_l, lock_l, wait_l} = lsync_q;

    // Pins and link levels into hclk; tck is sampled, not used as a clock
    spcp_sync #(.W(11)) u_sys_sync (
        .clk   (hclk),
        .rst_n (hresetn),
        .d     ({program_request_n, init_in, mode_pins, jtag_in.tck,
                 jtag_in.tms, jtag_in.tdi, req_tgl_reg, sdone_reg,
                 flash_image_valid}),
        .q     (hsync_q)
    );
    assign {prog_h, init_h, mode_h, tck_h, tms_h, tdi_h, req_h, sdone_h, flash_h} = hsync_q;

    // ---------------- Link domain ----------------
    logic       busy_reg;    // Throttle toward the host
    logic       cap;         // Byte taken at this edge
    logic       req_next;
    logic [7:0] scnt_reg;    // Start-up clock counter

    // Capture needs select and write low, port open and not throttled
    assign cap = open_l && !par_in.select_n && !par_in.write_direction_n && !busy_reg;
    assign req_next = cap ? ~req_tgl_reg : req_tgl_reg;

    // Byte capture on the rising config clock edge
    always_ff @(posedge config_clock or negedge hresetn) begin
        if (!hresetn) begin
            req_tgl_reg <= 1'b0;
            ldata_reg   <= 8'h00;
        end else if (cap) begin
            req_tgl_reg <= ~req_tgl_reg;
            ldata_reg   <= par_in.data;
        end
    end

    // Busy stays high until hclk side has taken the byte
    always_ff @(posedge config_clock or negedge hresetn) begin
        if (!hresetn) begin
            busy_reg <= 1'b0;
        end else begin
            busy_reg <= req_next ^ ack_l;
        end
    end

    // Start-up sequence paced by host clocks after the last byte
    always_ff @(posedge config_clock or negedge hresetn) begin
        if (!hresetn) begin
            scnt_reg  <= 8'h00;
            sdone_reg <= 1'b0;
        end else if (!start_l) begin
            // Withdrawn request ends the sequence at the third config clock edge, after the two-flop synchroniser
            scnt_reg  <= 8'h00;
            sdone_reg <= 1'b0;
        end else if (scnt_reg != spcp_pkg::STARTUP_CYCLES) begin
            scnt_reg <= scnt_reg + 8'h01;
        end else if (!wait_l || lock_l) begin
            // Optional wait for clock manager lock needs extra clocks
            sdone_reg <= 1'b1;
        end
    end

    // Flop-driven, so busy is defined at all times
    assign busy = busy_reg;

    // ---------------- hclk domain: loader ----------------
    spcp_pkg::spcp_state_e state_reg;
    spcp_pkg::spcp_state_e state_next;

    logic [2:0]  mode_reg;      // Mode latched at init release
    logic [7:0]  clr_cnt_reg;   // Clearing time counter
    logic        init_prev_reg; // For init rising edge
    logic        tck_prev_reg;  // For tck rising edge
    logic        prog_pulse;    // Software program request
    logic        prog_any;
    logic        par_mode;
    logic        jtag_ok;
    logic        par_evt;
    logic        jtag_evt;
    logic        tck_rise;
    logic [2:0]  jbit_reg;      // Scan bit position
    logic [7:0]  jsh_reg;       // Scan shifter
    logic        byte_evt;
    logic [7:0]  byte_val;
    logic [31:0] length_reg;
    logic [7:0]  check_reg;
    logic [31:0] count_reg;
    logic [7:0]  xor_reg;
    logic [7:0]  last_reg;
    logic [7:0]  jscnt_reg;     // Scan start-up counter
    logic        last_ok;
    logic        last_bad;
    logic        tdo_reg;

    assign prog_any = !prog_h || prog_pulse;
    assign tck_rise = tck_h && !tck_prev_reg;
    assign par_mode = (mode_reg == spcp_pkg::MODE_PARALLEL);

    // Scan loading: scan mode, or flash mode when STEPPING is nonzero or no flash image is valid
    assign jtag_ok = (mode_reg == spcp_pkg::MODE_JTAG) ||
                     ((mode_reg == spcp_pkg::MODE_FLASH) &&
                      ((STEPPING != 0) || !flash_h));

    // Parallel byte pending when toggles differ
    assign par_evt  = (req_h != ack_tgl_reg);
    assign jtag_evt = tck_rise && !tms_h && (jbit_reg == 3'h7);

    // Byte source: parallel port only in parallel mode
    always_comb begin
        byte_evt = 1'b0;
        byte_val = ldata_reg;
        if (state_reg == spcp_pkg::ST_LOAD) begin
            if (par_mode) begin
                byte_evt = par_evt;
                byte_val = ldata_reg;
            end else if (jtag_ok) begin
                byte_evt = jtag_evt;
                byte_val = {tdi_h, jsh_reg[7:1]};
            end
        end
    end

    assign last_ok  = byte_evt && ((count_reg + 32'h1) >= length_reg) &&
                      ((xor_reg ^ byte_val) == check_reg);
    assign last_bad = byte_evt && ((count_reg + 32'h1) >= length_reg) &&
                      ((xor_reg ^ byte_val) != check_reg);

    // Edge history for init and tck
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            init_prev_reg <= 1'b0;
            tck_prev_reg  <= 1'b0;
        end else begin
            init_prev_reg <= init_h;
            tck_prev_reg  <= tck_h;
        end
    end

    // Next state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            spcp_pkg::ST_CLEAR: begin
                // Hold clearing until program released and time spent
                if (!prog_any && clr_cnt_reg == spcp_pkg::CLEAR_CNT_MAX) begin
                    state_next = spcp_pkg::ST_INIT;
                end
            end
            spcp_pkg::ST_INIT: begin
                // Another device may still hold init low
                if (init_h && !init_prev_reg) begin
                    state_next = spcp_pkg::ST_LOAD;
                end
            end
            spcp_pkg::ST_LOAD: begin
                if (last_ok) begin
                    state_next = spcp_pkg::ST_START;
                end else if (last_bad) begin
                    state_next = spcp_pkg::ST_ERROR;
                end
            end
            spcp_pkg::ST_START: begin
                if (par_mode ? sdone_h : (jscnt_reg == spcp_pkg::STARTUP_CYCLES)) begin
                    state_next = spcp_pkg::ST_DONE;
                end
            end
            spcp_pkg::ST_DONE: begin
                state_next = spcp_pkg::ST_DONE;
            end
            spcp_pkg::ST_ERROR: begin
                state_next = spcp_pkg::ST_ERROR;
            end
            default: begin
                state_next = spcp_pkg::ST_CLEAR;
            end
        endcase
        // Program request wins from any state
        if (prog_any) begin
            state_next = spcp_pkg::ST_CLEAR;
        end
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= spcp_pkg::ST_CLEAR;
        end else begin
            state_reg <= state_next;
        end
    end

    // Clearing counter restarts on every program request
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clr_cnt_reg <= 8'h00;
        end else if (prog_any || state_reg != spcp_pkg::ST_CLEAR) begin
            clr_cnt_reg <= 8'h00;
        end else if (clr_cnt_reg != spcp_pkg::CLEAR_CNT_MAX) begin
            clr_cnt_reg <= clr_cnt_reg + 8'h01;
        end
    end

    // Mode latched on the rising init edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_reg <= 3'h0;
        end else if (state_reg == spcp_pkg::ST_INIT && init_h && !init_prev_reg) begin
            mode_reg <= mode_h;
        end
    end

    // Acknowledge every parallel byte so busy never sticks
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ack_tgl_reg <= 1'b0;
        end else if (par_evt) begin
            ack_tgl_reg <= req_h;
        end
    end

    // Scan shifter: bits LSB first while tms low
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            jbit_reg <= 3'h0;
            jsh_reg  <= 8'h00;
        end else if (state_reg != spcp_pkg::ST_LOAD) begin
            jbit_reg <= 3'h0;
        end else if (tck_rise && !tms_h && jtag_ok) begin
            jsh_reg  <= {tdi_h, jsh_reg[7:1]};
            jbit_reg <= jbit_reg + 3'h1;
        end
    end

    // Scan bypass bit works in every mode and state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tdo_reg <= 1'b0;
        end else if (tck_rise) begin
            tdo_reg <= tdi_h;
        end
    end

    // Scan start-up counted in tck rising edges
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            jscnt_reg <= 8'h00;
        end else if (state_reg != spcp_pkg::ST_START) begin
            jscnt_reg <= 8'h00;
        end else if (tck_rise && jscnt_reg != spcp_pkg::STARTUP_CYCLES) begin
            jscnt_reg <= jscnt_reg + 8'h01;
        end
    end

    // Byte counting, running check and last byte
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_reg <= 32'h0;
            xor_reg   <= 8'h00;
            last_reg  <= 8'h00;
        end else if (state_reg == spcp_pkg::ST_CLEAR) begin
            count_reg <= 32'h0;
            xor_reg   <= 8'h00;
        end else if (byte_evt) begin
            count_reg <= count_reg + 32'h1;
            xor_reg   <= xor_reg ^ byte_val;
            last_reg  <= byte_val;
        end
    end

    // Levels handed to the link domain
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            load_open_reg <= 1'b0;
            start_req_reg <= 1'b0;
        end else begin
            // Parallel pins are dead outside parallel loading
            load_open_reg <= (state_next == spcp_pkg::ST_LOAD) &&
                             (state_reg == spcp_pkg::ST_LOAD) && par_mode;
            start_req_reg <= (state_reg == spcp_pkg::ST_START) ||
                             (state_reg == spcp_pkg::ST_DONE);
        end
    end

    // Status pins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            done <= 1'b0;
        end else begin
            done <= (state_next == spcp_pkg::ST_DONE);
        end
    end

    // Init driven low while clearing and on error, else released
    assign init_out = 1'b0;
    assign init_oe  = (state_reg == spcp_pkg::ST_CLEAR) ||
                      (state_reg == spcp_pkg::ST_ERROR);
    assign tdo      = tdo_reg;

    // ---------------- AHB-Lite slave ----------------
    logic       wr_pend_reg;  // Write data phase pending
    logic [7:0] waddr_reg;    // Address of pending write
    logic       aphase;
    logic [31:0] rd_mux;
    logic [31:0] status_val;

    assign aphase = hsel && htrans[1] && hready;

    assign status_val = {16'h0, 1'b0, mode_reg, 1'b0, par_evt,
                         (state_reg == spcp_pkg::ST_ERROR), done,
                         2'b00, state_reg};

    // Read value chosen in the address phase
    always_comb begin
        case (haddr[7:0])
            spcp_pkg::ADDR_CTRL:   rd_mux = ctrl_reg;
            spcp_pkg::ADDR_LENGTH: rd_mux = length_reg;
            spcp_pkg::ADDR_CHECK:  rd_mux = {24'h0, check_reg};
            spcp_pkg::ADDR_STATUS: rd_mux = status_val;
            spcp_pkg::ADDR_COUNT:  rd_mux = count_reg;
            spcp_pkg::ADDR_LAST:   rd_mux = {24'h0, last_reg};
            default:               rd_mux = 32'h0;
        endcase
    end

    // Address phase capture and read data register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            waddr_reg   <= 8'h00;
            hrdata      <= 32'h0;
        end else begin
            wr_pend_reg <= aphase && hwrite;
            if (aphase) begin
                waddr_reg <= haddr[7:0];
                hrdata    <= hwrite ? 32'h0 : rd_mux;
            end
        end
    end

    // Register writes in the data phase; program bit self-clears
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg   <= 32'h0;
            length_reg <= spcp_pkg::LENGTH_RST;
            check_reg  <= spcp_pkg::CHECK_RST;
            prog_pulse <= 1'b0;
        end else begin
            prog_pulse <= 1'b0;
            if (wr_pend_reg) begin
                case (waddr_reg)
                    spcp_pkg::ADDR_CTRL: begin
                        ctrl_reg   <= {30'h0, hwdata[spcp_pkg::CTRL_LOCK_BIT], 1'b0};
                        prog_pulse <= hwdata[spcp_pkg::CTRL_PROG_BIT];
                    end
                    spcp_pkg::ADDR_LENGTH: length_reg <= hwdata;
                    spcp_pkg::ADDR_CHECK:  check_reg  <= hwdata[7:0];
                    default: ;
                endcase
            end
        end
    end

    // Zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

endmodule // spcp_top

// >>> sim/spcp_checker.sv
// Concurrent checks on the port pins and the bus answer
`timescale 1ns/1ps
module spcp_checker (
    // System side
    input wire logic                hclk,
    input wire logic                hresetn,
    input wire logic                hsel,
    input wire logic [1:0]          htrans,
    input wire logic                hreadyout,
    input wire logic                hresp,
    input wire logic [31:0]         hrdata,
    // Configuration pins
    input wire logic                config_clock,
    input wire logic                program_request_n,
    input wire spcp_pkg::spcp_par_s par_in,
    input wire logic                busy,
    input wire logic                done,
    input wire logic                init_oe
);
    // Zero wait states, OKAY only
    chk_ready_high: assert property (@(posedge hclk) disable iff (!hresetn) hreadyout)
        else $error("hreadyout low");
    chk_resp_okay: assert property (@(posedge hclk) disable iff (!hresetn) !hresp)
        else $error("hresp not okay");
    // Read data holds outside address phases
    chk_rdata_stands: assert property (@(posedge hclk) disable iff (!hresetn)
        $past(!(hsel && htrans[1])) |-> $stable(hrdata)) else $error("hrdata moved");
    // Busy only follows a selected write edge
    chk_busy_cause: assert property (@(posedge config_clock) disable iff (!hresetn)
        $rose(busy) |-> $past(!par_in.select_n && !par_in.write_direction_n)) else $error("busy unselected");
    // Busy never sticks while the host keeps clocking
    chk_busy_ends: assert property (@(posedge config_clock) disable iff (!hresetn)
        busy |-> ##[1:8] !busy) else $error("busy stuck");
    // Program request pulls init low and clears done
    chk_prog_clears: assert property (@(posedge hclk) disable iff (!hresetn)
        !program_request_n |-> ##[1:4] (init_oe && !done)) else $error("program ignored");
    // Clearing lasts past the end of the pulse
    chk_clear_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(program_request_n) |-> init_oe [*8]) else $error("clear too short");
    // Init released only with program high
    chk_init_release: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(init_oe) |-> program_request_n) else $error("init released early");
    // Success never with init low or busy
    chk_done_clean: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(done) |-> !init_oe && !busy) else $error("done while error");
endmodule // spcp_checker

// >>> sim/spcp_host_model.sv
// Behavioural download host that clocks bytes into the port
`timescale 1ns/1ps
module spcp_host_model (
    // Link pins
    output logic                config_clock,
    output spcp_pkg::spcp_par_s par_in,
    input wire logic            busy
);
    // Clock stands low between frames, port released
    initial begin
        config_clock = 1'b0;
        par_in = '{1'b1, 1'b1, 8'h00};
    end
    // One byte, held until an edge sees busy low; deselected takes one edge
    task send(input logic sel, input logic [7:0] b);
        logic bz;
        par_in <= '{~sel, 1'b0, b};
        #32;
        do begin
            bz = busy;
            config_clock = 1'b1;
            // Released lines show the inverse so stale data cannot pass
            if (bz === 1'b0 || !sel) par_in <= '{1'b1, 1'b1, ~b};
            #32 config_clock = 1'b0;
            #32;
        end while (bz !== 1'b0 && sel);
    endtask
    // Free clocks for start-up, port released
    task clocks(input int n);
        repeat (n) begin
            #32 config_clock = 1'b1;
            #32 config_clock = 1'b0;
        end
    endtask
endmodule // spcp_host_model

// >>> sim/slave_parallel_config_port_tb.sv
// Self-checking bench for the slave parallel configuration port
`timescale 1ns/1ps
module slave_parallel_config_port_tb;
    // Bus, pins and bench state
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, hready, config_clock, program_request_n;
    logic busy, done, init_in, init_out, init_oe, tdo, clock_manager_locked, flash_image_valid;
    logic [1:0]  htrans;
    logic [2:0]  hsize, mode_pins, m;
    logic [31:0] haddr, hwdata, hrdata, rd, seed;
    logic [7:0]  b [4];
    logic [7:0]  x;
    spcp_pkg::spcp_par_s  par_in;
    spcp_pkg::spcp_jtag_s jtag_in;
    int err_total, cmp_count;
    // One slave; open-drain line pulled up
    assign hready  = hreadyout;
    assign init_in = init_oe ? init_out : 1'b1;
    spcp_top u_spcp_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hreadyout, .hresp, .hrdata, .config_clock, .program_request_n, .mode_pins, .par_in, .busy,
        .done, .init_in, .init_out, .init_oe, .jtag_in, .tdo, .clock_manager_locked, .flash_image_valid);
    spcp_host_model u_spcp_host_model (.config_clock, .par_in, .busy);
    // System clock
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    // Bench random source
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task end_of_test;
        if (err_total == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task check(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    // Single word transfer; read data taken at the data-phase edge
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task rchk(input string n, input logic [7:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        check(n, e, rd);
    endtask
    // Program by pin or register, then wait for init release
    task prog_start(input logic [2:0] md, input logic via_reg);
        mode_pins <= md;
        if (via_reg) ahb(1'b1, spcp_pkg::ADDR_CTRL, 32'h1);
        else begin
            program_request_n <= 1'b0;
            repeat (8) @(posedge hclk);
            program_request_n <= 1'b1;
        end
        repeat (4) @(posedge hclk);
        for (int i = 0; i < 300 && init_oe !== 1'b0; i++) @(posedge hclk);
        u_spcp_host_model.clocks(3);
        check("init", 32'h0, {31'h0, init_oe});
        check("done cleared", 32'h0, {31'h0, done});
    endtask
    task wait_done;
        for (int i = 0; i < 300 && done !== 1'b1; i++) @(posedge hclk);
        check("done", 32'h1, {31'h0, done});
    endtask
    // Slow scan clocks, LSB first, bypass bit watched
    task scan(input logic [7:0] v);
        for (int i = 0; i < 8; i++) begin
            jtag_in <= '{1'b0, 1'b0, v[i]};
            repeat (6) @(posedge hclk);
            jtag_in.tck <= 1'b1;
            repeat (6) @(posedge hclk);
            check("tdo", {31'h0, v[i]}, {31'h0, tdo});
        end
    endtask
    // Main sequence
    initial begin
        hresetn = 1'b0; hsel = 1'b0; hwrite = 1'b0; htrans = 2'h0; hsize = 3'h2; haddr = 32'h0;
        hwdata = 32'h0; program_request_n = 1'b1; mode_pins = spcp_pkg::MODE_PARALLEL; jtag_in = '0;
        clock_manager_locked = 1'b0; flash_image_valid = 1'b0; seed = 32'd68257; err_total = 0; cmp_count = 0;
        u_spcp_host_model.clocks(2);
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        rchk("length rst", spcp_pkg::ADDR_LENGTH, spcp_pkg::LENGTH_RST);
        rchk("check rst", spcp_pkg::ADDR_CHECK, 32'h0);
        ahb(1'b1, 8'h18, 32'hffff_ffff);
        rchk("unmapped", 8'h18, 32'h0);
        ahb(1'b1, spcp_pkg::ADDR_COUNT, 32'hffff_ffff);
        rchk("count ro", spcp_pkg::ADDR_COUNT, 32'h0);
        // Parallel load, zero byte corner first, lock wait on
        x = 8'h00;
        foreach (b[i]) begin
            seed = lfsr(seed);
            b[i] = (i == 0) ? 8'h00 : seed[7:0];
            x ^= b[i];
        end
        ahb(1'b1, spcp_pkg::ADDR_LENGTH, 32'h4);
        ahb(1'b1, spcp_pkg::ADDR_CHECK, {24'h0, x});
        ahb(1'b1, spcp_pkg::ADDR_CTRL, 32'h2);
        prog_start(spcp_pkg::MODE_PARALLEL, 1'b0);
        ahb(1'b0, spcp_pkg::ADDR_STATUS, 32'h0);
        check("mode", 32'h6, {29'h0, rd[14:12]});
        u_spcp_host_model.send(1'b0, 8'h5a);
        foreach (b[i]) u_spcp_host_model.send(1'b1, b[i]);
        rchk("count", spcp_pkg::ADDR_COUNT, 32'h4);
        rchk("last", spcp_pkg::ADDR_LAST, {24'h0, b[3]});
        u_spcp_host_model.clocks(16);
        check("done early", 32'h0, {31'h0, done});
        clock_manager_locked <= 1'b1;
        u_spcp_host_model.clocks(16);
        wait_done;
        // Wrong check value ends in error
        ahb(1'b1, spcp_pkg::ADDR_CHECK, {24'h0, ~x});
        prog_start(spcp_pkg::MODE_PARALLEL, 1'b1);
        foreach (b[i]) u_spcp_host_model.send(1'b1, b[i]);
        u_spcp_host_model.clocks(4);
        ahb(1'b0, spcp_pkg::ADDR_STATUS, 32'h0);
        check("error", 32'h1, {31'h0, rd[9]});
        check("init err", 32'h1, {31'h0, init_oe});
        // Scan loading, scan mode then flash mode with a valid image
        ahb(1'b1, spcp_pkg::ADDR_CTRL, 32'h0);
        for (int k = 0; k < 2; k++) begin
            m = (k == 1) ? spcp_pkg::MODE_FLASH : spcp_pkg::MODE_JTAG;
            flash_image_valid <= (k == 1);
            seed = lfsr(seed);
            ahb(1'b1, spcp_pkg::ADDR_LENGTH, 32'h1);
            ahb(1'b1, spcp_pkg::ADDR_CHECK, {24'h0, seed[7:0]});
            prog_start(m, 1'b0);
            u_spcp_host_model.send(1'b1, 8'h3c);
            rchk("scan count", spcp_pkg::ADDR_COUNT, 32'h0);
            scan(seed[7:0]);
            scan(8'h00);
            wait_done;
        end
        end_of_test;
    end
    // Watchdog
    initial begin
        #2_000_000;
        err_total++;
        end_of_test;
    end
endmodule // slave_parallel_config_port_tb
bind spcp_top spcp_checker u_spcp_checker (.hclk, .hresetn, .hsel, .htrans, .hreadyout, .hresp, .hrdata,
    .config_clock, .program_request_n, .par_in, .busy, .done, .init_oe);
